/* sim/tb.sv */
// self-checking bench for the drop and egress register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
   import wrd_pkg::*;
   logic MCLK = 1'b0;
   logic RST_B = 1'b0;
   logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0, PRDATA, rd, mon;
   logic [3:0] PSTRB = 4'h0;
   logic PREADY, PSLVERR, DROP, TAG_OUT_VALID, err;
   logic POLICE_EN = 1'b1, TAG_VALID = 1'b0;
   logic [10:0] PM_AVG = 11'h5a3, PM_MULT;
   logic [43:0] Q_AVG = {11'h303, 11'h302, 11'h301, 11'h300};
   wrd_pkt_t PKT = '0;
   wrd_tags_t TAG_IN = '0, TAG_OUT;
   logic [11:0] DEFAULT_VID = 12'h5c7;
   logic [1:0] TXQ_SEL;
   int fail_count = 0, samples_checked = 0, cyc = 0;
   always #2 MCLK = ~MCLK;
   wrd_bank #(.NQ(4)) i_dut (.MCLK(MCLK), .RST_B(RST_B), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PSTRB(PSTRB), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
      .POLICE_EN(POLICE_EN), .PM_AVG(PM_AVG), .Q_AVG(Q_AVG), .PKT(PKT),
      .DROP(DROP), .TAG_VALID(TAG_VALID), .TAG_IN(TAG_IN),
      .DEFAULT_VID(DEFAULT_VID), .TAG_OUT_VALID(TAG_OUT_VALID),
      .TAG_OUT(TAG_OUT), .PM_MULT(PM_MULT), .TXQ_SEL(TXQ_SEL));
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   always @(posedge MCLK) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         finish_test;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d, input logic [3:0] s);
      logic got;
      @(posedge MCLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      PSTRB <= s;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      // answer read mid-cycle, taken at the edge that follows
      do begin
         @(negedge MCLK);
         got = PREADY;
         rd = PRDATA;
         err = PSLVERR;
         @(posedge MCLK);
      end while (got !== 1'b1);
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hf);
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, 4'h0);
      chk(rd, e);
   endtask
   // one packet, drop pulse looked at in the cycle after it
   task automatic pkt(input logic [1:0] c, input logic [1:0] q,
         input logic e);
      @(posedge MCLK);
      PKT <= '{valid: 1'b1, queue: q, color: wrd_color_t'(c)};
      @(posedge MCLK);
      PKT.valid <= 1'b0;
      #1 chk({31'h0, DROP}, {31'h0, e});
   endtask
   task automatic tag(input logic [24:0] t, input logic [24:0] e);
      @(posedge MCLK);
      TAG_IN <= t;
      TAG_VALID <= 1'b1;
      @(posedge MCLK);
      TAG_VALID <= 1'b0;
      #1 chk({6'h0, TAG_OUT_VALID, TAG_OUT}, {6'h0, 1'b1, e});
   endtask
   initial begin
      repeat (5) @(posedge MCLK);
      RST_B <= 1'b1;
      rchk(OFS_PM_CTRL1, {5'h0, RST_PM_MULT, 5'h0, PM_AVG});
      rchk(OFS_Q_THR, 32'h0080_0009);
      rchk(OFS_Q_MULT, {16'h0010, 5'h0, Q_AVG[10:0]});
      rchk(OFS_Q_MON, 32'h0);
      rchk(OFS_TXQ_SEL, 32'h0);
      rchk(OFS_VID_REPL, 32'h0);
      wr(OFS_PM_CTRL1, 32'hffff_ffff);
      rchk(OFS_PM_CTRL1, {16'h07ff, 5'h0, PM_AVG});
      chk({21'h0, PM_MULT}, 32'h7ff);
      rchk(12'h850, RD_UNMAPPED);
      chk({31'h0, err}, 32'h1);
      for (int q = 0; q < 4; q++) begin
         apb(1'b1, OFS_TXQ_SEL_B, 32'(q), 4'h1);
         wr(OFS_Q_THR, 32'h0040_0010 + 32'h0001_0001 * 32'(q));
         wr(OFS_Q_MULT, 32'h0100_07ff + 32'h0001_0000 * 32'(q));
      end
      for (int q = 0; q < 4; q++) begin
         wr(OFS_TXQ_SEL, 32'hffff_fffc | 32'(q));
         rchk(OFS_TXQ_SEL, 32'(q));
         rchk(OFS_Q_THR, 32'h0040_0010 + 32'h0001_0001 * 32'(q));
         rchk(OFS_Q_MULT, 32'h0100_0000 + 32'h0001_0000 * 32'(q)
            | {21'h0, Q_AVG[q*11+:11]});
      end
      wr(OFS_TXQ_SEL, 32'h0);
      mon = 32'h8400_0000;
      wr(OFS_Q_MON, mon);
      for (int i = 0; i < 3; i++) pkt(i[1:0], 2'd0, 1'b1);
      for (int i = 0; i < 3; i++) begin
         wr(OFS_Q_MON, mon | (32'h0800_0000 << i));
         pkt(2'd0, 2'd0, i != 2);
         pkt(2'd1, 2'd0, i == 0);
         pkt(2'd2, 2'd0, 1'b0);
      end
      rchk(OFS_Q_MON, mon | 32'h2000_0006);
      wr(OFS_Q_MON, mon);
      pkt(2'd0, 2'd1, 1'b1);
      rchk(OFS_Q_MON, mon | 32'h6);
      wr(OFS_TXQ_SEL, 32'h1);
      rchk(OFS_Q_MON, mon | 32'h1);
      wr(OFS_TXQ_SEL, 32'h0);
      @(posedge MCLK);
      POLICE_EN <= 1'b0;
      pkt(2'd0, 2'd0, 1'b0);
      POLICE_EN <= 1'b1;
      wr(OFS_Q_MON, 32'h0400_0000);
      pkt(2'd0, 2'd0, 1'b0);
      wr(OFS_Q_MON, mon);
      Q_AVG <= {4{11'h005}};
      pkt(2'd0, 2'd0, 1'b0);
      Q_AVG <= {4{11'h300}};
      wr(OFS_Q_MON, mon | 32'h4000_0000);
      rchk(OFS_Q_MON, mon | 32'h4000_0000);
      pkt(2'd0, 2'd0, 1'b1);
      wr(OFS_Q_MON, mon | 32'h4000_0000);
      rchk(OFS_Q_MON, mon | 32'h4000_0001);
      wr(OFS_TXQ_SEL, 32'h1);
      rchk(OFS_Q_MON, mon | 32'h4000_0000);
      tag({12'h123, 12'h000, 1'b0}, {12'h123, 12'h000, 1'b0});
      wr(OFS_VID_REPL, 32'hffff_ffff);
      rchk(OFS_VID_REPL, 32'h1);
      tag({12'h123, 12'h000, 1'b0}, {DEFAULT_VID, 12'h000, 1'b0});
      tag({12'h000, 12'h000, 1'b0}, {12'h000, 12'h000, 1'b0});
      tag({12'h123, 12'h456, 1'b1}, {12'h123, DEFAULT_VID, 1'b1});
      finish_test;
   end
endmodule // tb
`default_nettype wire

/* sim/wrd_bank_monitor.sv */
// assertion checker for the drop and egress register bank
`timescale 1ns/1ps
`default_nettype none
module wrd_bank_monitor
   import wrd_pkg::*;
#(
   parameter int NQ = 4
) (
   input wire logic MCLK, // clock
   input wire logic RST_B, // reset, active low
   input wire logic PSEL, // select
   input wire logic PENABLE, // access phase
   input wire logic PWRITE, // direction
   input wire logic [11:0] PADDR, // address
   input wire logic [31:0] PWDATA, // write data
   input wire logic [3:0] PSTRB, // strobes
   input wire logic PREADY, // ready
   input wire logic [31:0] PRDATA, // read data
   input wire logic PSLVERR, // error
   input wire logic POLICE_EN, // policing enable
   input wire logic [10:0] PM_AVG, // memory average
   input wire logic [NQ*11-1:0] Q_AVG, // queue averages
   input wire wrd_pkg::wrd_pkt_t PKT, // packet
   input wire logic DROP, // drop pulse
   input wire logic TAG_VALID, // tag strobe
   input wire wrd_pkg::wrd_tags_t TAG_IN, // tags in
   input wire logic [11:0] DEFAULT_VID, // default vlan tag
   input wire logic TAG_OUT_VALID, // tag out strobe
   input wire wrd_pkg::wrd_tags_t TAG_OUT, // tags out
   input wire logic [10:0] PM_MULT, // memory multiplier
   input wire logic [QSEL_W-1:0] TXQ_SEL // queue index
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_B);
   wire logic wr_acc;
   wire logic txq_hit;
   assign wr_acc = PSEL && PENABLE && PREADY && PWRITE;
   assign txq_hit = PADDR == OFS_TXQ_SEL || PADDR == OFS_TXQ_SEL_B;
   sequence s_pm_wr;
      wr_acc && PADDR == OFS_PM_CTRL1 && PSTRB == 4'hf;
   endsequence
   sequence s_tag_zero;
      TAG_VALID && !TAG_IN.double_tag && TAG_IN.inner_vid == 12'h000;
   endsequence
   property p_pm_hold;
      !(wr_acc && PADDR == OFS_PM_CTRL1) |=> $stable(PM_MULT);
   endproperty
   property p_pm_val;
      s_pm_wr |=> PM_MULT == $past(PWDATA[26:16]);
   endproperty
   property p_pm_read;
      PSEL && PENABLE && !PWRITE && PADDR == OFS_PM_CTRL1
         |-> PRDATA[10:0] == $past(PM_AVG) && PRDATA[26:16] == PM_MULT;
   endproperty
   property p_txq_hold;
      !(wr_acc && txq_hit) |=> $stable(TXQ_SEL);
   endproperty
   property p_txq_val;
      wr_acc && txq_hit && PSTRB[0] |=> TXQ_SEL == $past(PWDATA[1:0]);
   endproperty
   property p_tag_pulse;
      TAG_VALID |=> TAG_OUT_VALID;
   endproperty
   property p_tag_zero;
      s_tag_zero |=> TAG_OUT.inner_vid == 12'h000;
   endproperty
   property p_tag_double;
      TAG_VALID && TAG_IN.double_tag
         |=> TAG_OUT.inner_vid == $past(TAG_IN.inner_vid);
   endproperty
   property p_drop_cause;
      DROP |-> $past(PKT.valid) && $past(POLICE_EN);
   endproperty
   a_pm_hold: assert property (p_pm_hold)
      else $error("memory multiplier moved without a write");
   a_pm_val: assert property (p_pm_val)
      else $error("memory multiplier not written");
   a_pm_read: assert property (p_pm_read)
      else $error("memory control read wrong");
   a_txq_hold: assert property (p_txq_hold)
      else $error("queue index moved without a write");
   a_txq_val: assert property (p_txq_val)
      else $error("queue index not written");
   a_tag_pulse: assert property (p_tag_pulse)
      else $error("edited tag strobe missing");
   a_tag_zero: assert property (p_tag_zero)
      else $error("zero vlan id was replaced");
   a_tag_double: assert property (p_tag_double)
      else $error("inner id changed on double tag");
   a_drop_cause: assert property (p_drop_cause)
      else $error("drop without packet or enable");
endmodule // wrd_bank_monitor

bind wrd_bank wrd_bank_monitor #(.NQ(NQ)) i_mon (.MCLK(MCLK), .RST_B(RST_B),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
   .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY), .PRDATA(PRDATA),
   .PSLVERR(PSLVERR), .POLICE_EN(POLICE_EN), .PM_AVG(PM_AVG),
   .Q_AVG(Q_AVG), .PKT(PKT), .DROP(DROP), .TAG_VALID(TAG_VALID),
   .TAG_IN(TAG_IN), .DEFAULT_VID(DEFAULT_VID),
   .TAG_OUT_VALID(TAG_OUT_VALID), .TAG_OUT(TAG_OUT), .PM_MULT(PM_MULT),
   .TXQ_SEL(TXQ_SEL));
`default_nettype wire

/* src/wrd_bank.sv */
// drop and egress register bank behind an apb slave
`timescale 1ns/1ps
`default_nettype none
// Operation
// - memory drop multiplier rw, reset 0x020
// - memory average occupancy read only
// - queue upper threshold rw, reset 0x080
// - queue lower threshold rw, reset 0x009
// - queue drop multiplier rw, reset 0x010
// - selected queue average size read only
// - per-queue fields follow the queue index
// - random dropping only while enable bit set
// - counters cleared on clear bit rising
// - all-color inhibit stops every drop
// - yellow/red inhibit stops those drops
// - red inhibit stops red drops
// - drop-all above upper threshold, else probabilistic
// - 24-bit event count, reset zero, read only
// - 2-bit queue index rw, reset zero
// - queue index also reachable as byte
// - replace nonzero egress vlan id when enabled
// - double tagged: replace outer tag id
// - dropping only with policing enable set
module wrd_bank
   import wrd_pkg::*;
#(
   parameter int NQ = 4
) (
   input wire logic MCLK, // system clock
   input wire logic RST_B, // async reset, active low
   input wire logic PSEL, // apb select
   input wire logic PENABLE, // apb access phase
   input wire logic PWRITE, // apb direction
   input wire logic [11:0] PADDR, // apb byte address
   input wire logic [31:0] PWDATA, // apb write data
   input wire logic [3:0] PSTRB, // apb byte strobes
   output logic PREADY, // apb ready
   output logic [31:0] PRDATA, // apb read data
   output logic PSLVERR, // apb error on unmapped
   input wire logic POLICE_EN, // port policing enable
   input wire logic [10:0] PM_AVG, // memory average occupancy
   input wire logic [NQ*11-1:0] Q_AVG, // per-queue averages
   input wire wrd_pkg::wrd_pkt_t PKT, // packet to judge
   output logic DROP, // drop pulse for PKT
   input wire logic TAG_VALID, // egress tag strobe
   input wire wrd_pkg::wrd_tags_t TAG_IN, // egress tags
   input wire logic [11:0] DEFAULT_VID, // port default vlan tag
   output logic TAG_OUT_VALID, // edited tag strobe
   output wrd_pkg::wrd_tags_t TAG_OUT, // edited tags
   output logic [10:0] PM_MULT, // memory drop multiplier
   output logic [QSEL_W-1:0] TXQ_SEL // queue index
);
   import wrd_pkg::*;

   // register state
   logic [10:0] pm_mult_reg;
   logic [10:0] q_max_reg [NQ];
   logic [10:0] q_min_reg [NQ];
   logic [10:0] q_mult_reg [NQ];
   logic [5:0] mon_reg;
   logic [QSEL_W-1:0] qsel_reg;
   logic vid_repl_reg;
   logic [31:0] prdata_reg;
   logic slverr_reg;
   wrd_tags_t tag_out_reg;
   logic tag_valid_reg;
   wrd_apb_st_t st_reg, st_next;

   // bus decode
   logic setup, access, wr_access;
   logic hit_pm, hit_thr, hit_mult, hit_mon, hit_sel, hit_selb, hit_vid;
   logic mapped;
   logic wr_pm, wr_thr, wr_mult, wr_mon, wr_sel, wr_selb, wr_vid;
   logic [31:0] rd_word;
   logic [31:0] rd_pm, rd_thr, rd_mult, rd_mon, rd_sel, rd_selb, rd_vid;
   logic [CNT_W-1:0] cnt_sel;
   logic [10:0] q_avg_sel;
   wrd_mode_t mode;
   logic [31:0] wmask;

   assign setup = PSEL && !PENABLE;
   assign access = PSEL && PENABLE;
   assign wr_access = access && PWRITE;
   assign hit_pm = PADDR == OFS_PM_CTRL1;
   assign hit_thr = PADDR == OFS_Q_THR;
   assign hit_mult = PADDR == OFS_Q_MULT;
   assign hit_mon = PADDR == OFS_Q_MON;
   assign hit_sel = PADDR == OFS_TXQ_SEL;
   assign hit_selb = PADDR == OFS_TXQ_SEL_B;
   assign hit_vid = PADDR == OFS_VID_REPL;
   assign mapped = hit_pm || hit_thr || hit_mult || hit_mon
                   || hit_sel || hit_selb || hit_vid;

   // byte strobes widened to a bit mask
   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_mask
         assign wmask[b*8 +: 8] = {8{PSTRB[b]}};
      end
   endgenerate

   assign wr_pm = wr_access && hit_pm;
   assign wr_thr = wr_access && hit_thr;
   assign wr_mult = wr_access && hit_mult;
   assign wr_mon = wr_access && hit_mon;
   assign wr_sel = wr_access && hit_sel;
   assign wr_selb = wr_access && hit_selb;
   assign wr_vid = wr_access && hit_vid;

   // selected queue views
   assign q_avg_sel = Q_AVG[qsel_reg*11 +: 11];

   assign rd_pm = {5'h00, pm_mult_reg, 5'h00, PM_AVG};
   assign rd_thr = {5'h00, q_max_reg[qsel_reg],
                    5'h00, q_min_reg[qsel_reg]};
   assign rd_mult = {5'h00, q_mult_reg[qsel_reg],
                     5'h00, q_avg_sel};
   assign rd_mon = {mon_reg, 2'h0, cnt_sel};
   assign rd_sel = {30'h0, qsel_reg};
   assign rd_selb = {30'h0, qsel_reg};
   assign rd_vid = {31'h0, vid_repl_reg};

   assign rd_word = hit_pm ? rd_pm
                  : hit_thr ? rd_thr
                  : hit_mult ? rd_mult
                  : hit_mon ? rd_mon
                  : hit_sel ? rd_sel
                  : hit_selb ? rd_selb
                  : hit_vid ? rd_vid
                  : RD_UNMAPPED;

   // bus phase tracking; answer always one cycle after setup
   always_comb begin
      st_next = st_reg;
      unique case (st_reg)
         WRD_IDLE: begin
            if (setup)
               st_next = WRD_SETUP;
         end
         WRD_SETUP: begin
            st_next = WRD_ACCESS;
         end
         WRD_ACCESS: begin
            st_next = setup ? WRD_SETUP : WRD_IDLE;
         end
         default: begin
            st_next = WRD_IDLE;
         end
      endcase
   end

   assign PREADY = access && st_reg == WRD_SETUP;
   assign PRDATA = prdata_reg;
   assign PSLVERR = PREADY && slverr_reg;

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B)
         st_reg <= WRD_IDLE;
      else
         st_reg <= st_next;
   end

   // read data captured in the setup cycle
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         prdata_reg <= RD_UNMAPPED;
         slverr_reg <= 1'b0;
      end else if (setup) begin
         prdata_reg <= PWRITE ? RD_UNMAPPED : rd_word;
         slverr_reg <= !mapped;
      end
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B)
         pm_mult_reg <= RST_PM_MULT;
      else if (wr_pm)
         pm_mult_reg <= (pm_mult_reg & ~wmask[HI_LSB +: FW])
                        | (PWDATA[HI_LSB +: FW] & wmask[HI_LSB +: FW]);
   end

   // per-queue configuration, written through the index
   genvar q;
   generate
      for (q = 0; q < NQ; q++) begin : g_qcfg
         logic sel;
         assign sel = qsel_reg == QSEL_W'(q);
         always_ff @(posedge MCLK or negedge RST_B) begin
            if (!RST_B) begin
               q_max_reg[q] <= RST_Q_MAX;
               q_min_reg[q] <= RST_Q_MIN;
               q_mult_reg[q] <= RST_Q_MULT;
            end else begin
               if (wr_thr && sel) begin
                  q_max_reg[q] <= (q_max_reg[q] & ~wmask[HI_LSB +: FW])
                     | (PWDATA[HI_LSB +: FW] & wmask[HI_LSB +: FW]);
                  q_min_reg[q] <= (q_min_reg[q] & ~wmask[LO_LSB +: FW])
                     | (PWDATA[LO_LSB +: FW] & wmask[LO_LSB +: FW]);
               end
               if (wr_mult && sel)
                  q_mult_reg[q] <= (q_mult_reg[q] & ~wmask[HI_LSB +: FW])
                     | (PWDATA[HI_LSB +: FW] & wmask[HI_LSB +: FW]);
            end
         end
      end
   endgenerate

   // monitor control bits 31:26; the counter field ignores writes
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B)
         mon_reg <= 6'h00;
      else if (wr_mon && PSTRB[3])
         mon_reg <= PWDATA[MON_DROP_ALL +: 6];
   end

   // queue index: word access or byte alias in the low lane
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B)
         qsel_reg <= '0;
      else if (wr_sel && PSTRB[0])
         qsel_reg <= PWDATA[QSEL_W-1:0];
      else if (wr_selb && PSTRB[0])
         qsel_reg <= PWDATA[QSEL_W-1:0];
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B)
         vid_repl_reg <= 1'b0;
      else if (wr_vid && PSTRB[0])
         vid_repl_reg <= PWDATA[VID_REPL_BIT];
   end

   assign mode.rand_en = mon_reg[MON_RAND_EN-MON_DROP_ALL];
   assign mode.all_inh = mon_reg[MON_ALL_INH-MON_DROP_ALL];
   assign mode.yr_inh = mon_reg[MON_YR_INH-MON_DROP_ALL];
   assign mode.red_inh = mon_reg[MON_RED_INH-MON_DROP_ALL];
   assign mode.drop_all = mon_reg[0];

   // drop path judges the packet's own queue
   wrd_drop_decide u_decide (
      .clk(MCLK),
      .rst_b(RST_B),
      .pkt(PKT),
      .mode(mode),
      .enable(POLICE_EN),
      .q_avg(Q_AVG[PKT.queue*11 +: 11]),
      .q_min(q_min_reg[PKT.queue]),
      .q_max(q_max_reg[PKT.queue]),
      .q_mult(q_mult_reg[PKT.queue]),
      .drop(DROP)
   );

   // drop events are what the counters record
   logic [QSEL_W-1:0] drop_q_reg;
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B)
         drop_q_reg <= '0;
      else
         drop_q_reg <= PKT.queue;
   end

   wrd_event_count #(
      .NQ(NQ)
   ) u_count (
      .clk(MCLK),
      .rst_b(RST_B),
      .clear_lvl(mon_reg[MON_CLEAR-MON_DROP_ALL]),
      .inc(DROP),
      .inc_q(drop_q_reg),
      .rd_q(qsel_reg),
      .count(cnt_sel)
   );

   // egress vlan id replacement
   wrd_tags_t tag_next;
   logic repl_inner, repl_outer;
   assign repl_outer = vid_repl_reg && TAG_IN.double_tag
                       && TAG_IN.outer_vid != 12'h000;
   assign repl_inner = vid_repl_reg && !TAG_IN.double_tag
                       && TAG_IN.inner_vid != 12'h000;
   assign tag_next.double_tag = TAG_IN.double_tag;
   assign tag_next.outer_vid = repl_outer ? DEFAULT_VID
                                          : TAG_IN.outer_vid;
   assign tag_next.inner_vid = repl_inner ? DEFAULT_VID
                                          : TAG_IN.inner_vid;

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         tag_out_reg <= '0;
         tag_valid_reg <= 1'b0;
      end else begin
         tag_valid_reg <= TAG_VALID;
         if (TAG_VALID)
            tag_out_reg <= tag_next;
      end
   end

   assign TAG_OUT = tag_out_reg;
   assign TAG_OUT_VALID = tag_valid_reg;
   assign PM_MULT = pm_mult_reg;
   assign TXQ_SEL = qsel_reg;
endmodule // wrd_bank
`default_nettype wire

/* src/wrd_drop_decide.sv */
// drop decision for one packet against the thresholds of the packet's own queue
`timescale 1ns/1ps
`default_nettype none
module wrd_drop_decide
   import wrd_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic rst_b, // async reset, active low
   input wire wrd_pkg::wrd_pkt_t pkt, // packet to judge
   input wire wrd_pkg::wrd_mode_t mode, // monitor control bits
   input wire logic enable, // policing enable
   input wire logic [10:0] q_avg, // averaged queue size
   input wire logic [10:0] q_min, // lower threshold
   input wire logic [10:0] q_max, // upper threshold
   input wire logic [10:0] q_mult, // probability multiplier
   output logic drop // one-cycle drop pulse
);
   logic [15:0] lfsr_reg;
   logic drop_reg;
   logic [21:0] scaled;
   logic [10:0] excess;
   logic inhibit;
   logic below, above, prob_hit, want;

   assign excess = q_avg - q_min;
   assign scaled = excess * q_mult;
   assign below = q_avg < q_min;
   assign above = q_avg > q_max;
   // probability grows with fill and with the multiplier
   assign prob_hit = above ? (lfsr_reg[10:0] < q_mult)
                           : (lfsr_reg < scaled[21:6]);
   assign inhibit = mode.all_inh
      || (mode.yr_inh && pkt.color != WRD_GREEN)
      || (mode.red_inh && pkt.color == WRD_RED);
   assign want = (above && mode.drop_all) || (!below && prob_hit);
   assign drop = drop_reg;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lfsr_reg <= RST_LFSR;
         drop_reg <= 1'b0;
      end else begin
         lfsr_reg <= {lfsr_reg[14:0],
                      lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
         drop_reg <= pkt.valid && enable && mode.rand_en
                     && !inhibit && want;
      end
   end
endmodule // wrd_drop_decide
`default_nettype wire

/* src/wrd_event_count.sv */
// per-queue packet event counters with edge-triggered clear
`timescale 1ns/1ps
`default_nettype none
module wrd_event_count
   import wrd_pkg::*;
#(
   parameter int NQ = 4
) (
   input wire logic clk, // system clock
   input wire logic rst_b, // async reset, active low
   input wire logic clear_lvl, // clear control level
   input wire logic inc, // count one event
   input wire logic [QSEL_W-1:0] inc_q, // queue of the event
   input wire logic [QSEL_W-1:0] rd_q, // queue shown to software
   output logic [CNT_W-1:0] count // selected count
);
   logic clear_d_reg;
   logic clear_pulse;
   logic [CNT_W-1:0] cnt_reg [NQ];

   assign clear_pulse = clear_lvl && !clear_d_reg;
   assign count = cnt_reg[rd_q];

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         clear_d_reg <= 1'b0;
      else
         clear_d_reg <= clear_lvl;
   end

   genvar g;
   generate
      for (g = 0; g < NQ; g++) begin : g_q
         logic hit;
         assign hit = inc && (inc_q == QSEL_W'(g));
         // an event in the clearing cycle survives as a count of one
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b)
               cnt_reg[g] <= '0;
            else if (clear_pulse)
               cnt_reg[g] <= CNT_W'(hit);
            else if (hit)
               cnt_reg[g] <= cnt_reg[g] + CNT_W'(1);
         end
      end
   endgenerate
endmodule // wrd_event_count
`default_nettype wire

/* src/wrd_pkg.sv */
// package: register map, fields, resets and types for the drop bank
package wrd_pkg;
   localparam logic [11:0] OFS_PM_CTRL1 = 12'h834;
   localparam logic [11:0] OFS_Q_THR = 12'h840;
   localparam logic [11:0] OFS_Q_MULT = 12'h844;
   localparam logic [11:0] OFS_Q_MON = 12'h848;
   localparam logic [11:0] OFS_TXQ_SEL = 12'h900;
   localparam logic [11:0] OFS_TXQ_SEL_B = 12'h903;
   localparam logic [11:0] OFS_VID_REPL = 12'h904;
   localparam int HI_LSB = 16;
   localparam int LO_LSB = 0;
   localparam int FW = 11;
   localparam int CNT_W = 24;
   localparam int QSEL_W = 2;
   localparam int MON_RAND_EN = 31;
   localparam int MON_CLEAR = 30;
   localparam int MON_ALL_INH = 29;
   localparam int MON_YR_INH = 28;
   localparam int MON_RED_INH = 27;
   localparam int MON_DROP_ALL = 26;
   localparam int VID_REPL_BIT = 0;
   localparam logic [10:0] RST_PM_MULT = 11'h020;
   localparam logic [10:0] RST_Q_MAX = 11'h080;
   localparam logic [10:0] RST_Q_MIN = 11'h009;
   localparam logic [10:0] RST_Q_MULT = 11'h010;
   localparam logic [15:0] RST_LFSR = 16'hace1;
   localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

   typedef enum logic [1:0] {
      WRD_GREEN,
      WRD_YELLOW,
      WRD_RED,
      WRD_NOCOLOR
   } wrd_color_t;

   typedef struct packed {
      logic valid;
      logic [QSEL_W-1:0] queue;
      wrd_color_t color;
   } wrd_pkt_t;

   typedef struct packed {
      logic [11:0] inner_vid;
      logic [11:0] outer_vid;
      logic double_tag;
   } wrd_tags_t;

   typedef struct packed {
      logic rand_en;
      logic all_inh;
      logic yr_inh;
      logic red_inh;
      logic drop_all;
   } wrd_mode_t;

   typedef enum logic [1:0] {
      WRD_IDLE,
      WRD_SETUP,
      WRD_ACCESS
   } wrd_apb_st_t;
endpackage
